/* File: include/fetar_map.vh */
// flash erase timing and auto-read block: offsets, fields, reset values
// assumes word-indexed cpu register port and an information block memory
// Operation
// - page erase pulse 4096 x (width+1) ticks
// - module erase pulse 4096 x (width+1) ticks
// - end delay (field+1) ticks after operation
// - module erase end delay 8 x (field+1)
// - recovery delay (field+1) ticks between accesses
// - reset loads page 04h, module EAh
// - reset loads end 18h, mend 3Ch, recovery 04h
// - function word copied at reset, read-only
// - function bit0 low forces usb low-power
// - protection word copied at reset, read-only
// - code start loaded at reset, branch follows
// - code start bits 8:0, 15:13 read zero
// - code start 12:9 = inverted boot bits
// - alias index returns same auto-read value
// - prescaler divides clock by divisor+1
// - busy while operating, stalls flash requests
`ifndef FETAR_MAP_VH
`define FETAR_MAP_VH

// ==========================================================
// register indices
`define FETAR_IDX_PRESCALE     4'h0
`define FETAR_IDX_PAGE_ERASE   4'h1
`define FETAR_IDX_MOD_ERASE    4'h2
`define FETAR_IDX_END          4'h3
`define FETAR_IDX_MOD_END      4'h4
`define FETAR_IDX_RECOVERY     4'h5
`define FETAR_IDX_FUNC_WORD    4'h6
`define FETAR_IDX_PROT_WORD    4'h7
`define FETAR_IDX_CODE_START   4'h8
`define FETAR_IDX_FUNC_ALIAS   4'h9
`define FETAR_IDX_PROT_ALIAS   4'hA
`define FETAR_IDX_CODE_ALIAS   4'hB
`define FETAR_IDX_STATUS       4'hC

// ==========================================================
// reset values
`define FETAR_RST_PRESCALE     5'h04
`define FETAR_RST_PAGE_ERASE   8'h04
`define FETAR_RST_MOD_ERASE    8'hEA
`define FETAR_RST_END          8'h18
`define FETAR_RST_MOD_END      8'h3C
`define FETAR_RST_RECOVERY     8'h04

// ==========================================================
// fields and timing
`define FETAR_INFO_ADDR_FUNC   2'h0
`define FETAR_INFO_ADDR_PROT   2'h1
`define FETAR_FUNC_USB_BIT     0
`define FETAR_BOOT_MSB         3
`define FETAR_BOOT_LSB         0
`define FETAR_CODE_MSB         12
`define FETAR_CODE_LSB         9
`define FETAR_ERASE_SHIFT      12
`define FETAR_MOD_END_SHIFT    3
`define FETAR_OP_PROGRAM       2'h0
`define FETAR_OP_PAGE_ERASE    2'h1
`define FETAR_OP_MOD_ERASE     2'h2

`endif

/* File: core/fetar_info_mem.v */
// information block word store with registered read data
// assumes writes come from the flash programming path on clock_in
`timescale 1ns/1ps
module fetar_info_mem #(
  parameter DW = 16,
  parameter AW = 2
) (
  input  wire          clock_in,
  input  wire          ce_in,
  input  wire          wr_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  input  wire          rd_in,
  input  wire [AW-1:0] raddr_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // no reset on storage: contents model non-volatile words
  always @(posedge clock_in) begin
    if (ce_in) begin
      if (wr_in) begin
        mem_r[waddr_in] <= wdata_in;
      end
      if (rd_in) begin
        rdata_out <= mem_r[raddr_in];
      end
    end
  end

endmodule // fetar_info_mem

/* File: core/fetar_top.v */
// flash erase/end/recovery timing reloads, sequencer and auto-read copies
// assumes cpu port and op requests on clock_in; info words preloaded
`timescale 1ns/1ps
`include "fetar_map.vh"
module fetar_top #(
  parameter [20:0] PROG_TICKS = 21'h00_0008
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire        cpu_sel_in,
  input  wire        cpu_wr_in,
  input  wire [3:0]  cpu_addr_in,
  input  wire [7:0]  cpu_wdata_in,
  output reg  [15:0] cpu_rdata_out,
  input  wire        flash_req_in,
  output reg         cpu_stall_out,
  input  wire        op_start_in,
  input  wire [1:0]  op_kind_in,
  output reg         busy_out,
  output reg         prog_pulse_out,
  output reg         erase_pulse_out,
  output reg         presc_tick_out,
  input  wire        info_wr_in,
  input  wire [1:0]  info_waddr_in,
  input  wire [15:0] info_wdata_in,
  input  wire        usb_suspend_in,
  output reg         usb_lowpower_out,
  output reg         boot_branch_out,
  output reg  [15:0] boot_disp_out
);

  // ==========================================================
  // state codes
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_PULSE  = 3'h1;
  localparam [2:0] ST_END    = 3'h2;
  localparam [2:0] ST_MEND   = 3'h3;
  localparam [2:0] ST_RCV    = 3'h4;
  localparam [1:0] IN_RD0    = 2'h0;
  localparam [1:0] IN_RD1    = 2'h1;
  localparam [1:0] IN_CAP1   = 2'h2;
  localparam [1:0] IN_DONE   = 2'h3;

  // ==========================================================
  // registers
  reg [4:0]  presc_div_r;
  reg [7:0]  page_erase_r;
  reg [7:0]  mod_erase_r;
  reg [7:0]  end_r;
  reg [7:0]  mod_end_r;
  reg [7:0]  recovery_r;
  reg [15:0] func_word_r;
  reg [15:0] prot_word_r;
  reg [3:0]  code_bits_r;
  reg [4:0]  presc_cnt_r;
  reg        tick_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [1:0]  op_r;
  reg [20:0] cnt_r;
  reg [20:0] cnt_nxt;
  reg [1:0]  init_r;
  reg [15:0] rdata_nxt;
  reg        busy_nxt;

  wire        cpu_write;
  wire        mem_rd;
  wire [1:0]  mem_raddr;
  wire [15:0] mem_rdata;
  wire [15:0] code_start;
  wire        init_done;

  assign cpu_write = cpu_sel_in & cpu_wr_in;
  assign init_done = (init_r == IN_DONE);
  assign mem_rd    = (init_r == IN_RD0) | (init_r == IN_RD1);
  assign mem_raddr = (init_r == IN_RD0) ? `FETAR_INFO_ADDR_FUNC : `FETAR_INFO_ADDR_PROT;

  assign code_start = {3'h0, code_bits_r, 9'h000};

  // ==========================================================
  // phase length decode
  // tick counts per phase
  function [20:0] phase_len;
    input [2:0] st;
    input [1:0] op;
    input [7:0] per;
    input [7:0] mer;
    input [7:0] endf;
    input [7:0] mendf;
    input [7:0] rcvf;
    reg   [8:0] sel;
    begin
      sel = 9'h000;
      phase_len = 21'h00_0001;
      case (st)
        ST_PULSE: begin
          if (op == `FETAR_OP_PROGRAM) begin
            phase_len = PROG_TICKS;
          end else begin
            sel = (op == `FETAR_OP_MOD_ERASE) ? {1'b0, mer} + 9'h001 : {1'b0, per} + 9'h001;
            phase_len = {sel, 12'h000};
          end
        end
        ST_END: begin
          sel = {1'b0, endf} + 9'h001;
          phase_len = {12'h000, sel};
        end
        ST_MEND: begin
          sel = {1'b0, mendf} + 9'h001;
          phase_len = {9'h000, sel, 3'h0};
        end
        ST_RCV: begin
          sel = {1'b0, rcvf} + 9'h001;
          phase_len = {12'h000, sel};
        end
        default: begin
          phase_len = 21'h00_0001;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // info block memory
  fetar_info_mem #(
    .DW (16),
    .AW (2)
  ) u_info_mem (
    .clock_in  (clock_in),
    .ce_in     (ce_in),
    .wr_in     (info_wr_in),
    .waddr_in  (info_waddr_in),
    .wdata_in  (info_wdata_in),
    .rd_in     (mem_rd),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  // ==========================================================
  // timing reload registers
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      presc_div_r  <= `FETAR_RST_PRESCALE;
      page_erase_r <= `FETAR_RST_PAGE_ERASE;
      mod_erase_r  <= `FETAR_RST_MOD_ERASE;
      end_r        <= `FETAR_RST_END;
      mod_end_r    <= `FETAR_RST_MOD_END;
      recovery_r   <= `FETAR_RST_RECOVERY;
    end else if (ce_in) begin
      // only cpu writes change reloads
      // writes while busy are software's fault, still taken
      if (cpu_write) begin
        if (cpu_addr_in == `FETAR_IDX_PRESCALE) begin
          presc_div_r <= cpu_wdata_in[4:0];
        end else if (cpu_addr_in == `FETAR_IDX_PAGE_ERASE) begin
          page_erase_r <= cpu_wdata_in;
        end else if (cpu_addr_in == `FETAR_IDX_MOD_ERASE) begin
          mod_erase_r <= cpu_wdata_in;
        end else if (cpu_addr_in == `FETAR_IDX_END) begin
          end_r <= cpu_wdata_in;
        end else if (cpu_addr_in == `FETAR_IDX_MOD_END) begin
          mod_end_r <= cpu_wdata_in;
        end else if (cpu_addr_in == `FETAR_IDX_RECOVERY) begin
          recovery_r <= cpu_wdata_in;
        end
      end
    end
  end

  // ==========================================================
  // prescaler
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      presc_cnt_r <= 5'h00;
      tick_r      <= 1'b0;
    end else if (ce_in) begin
      if (presc_cnt_r >= presc_div_r) begin
        presc_cnt_r <= 5'h00;
        tick_r      <= 1'b1;
      end else begin
        presc_cnt_r <= presc_cnt_r + 5'h01;
        tick_r      <= 1'b0;
      end
    end
  end

  // ==========================================================
  // auto-read capture after reset release
  // captured by clocked logic, never under the async reset itself
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      init_r      <= IN_RD0;
      func_word_r <= 16'h0000;
      prot_word_r <= 16'h0000;
      code_bits_r <= 4'h0;
    end else if (ce_in) begin
      case (init_r)
        IN_RD0: begin
          init_r <= IN_RD1;
        end
        IN_RD1: begin
          func_word_r <= mem_rdata;
          init_r      <= IN_CAP1;
        end
        IN_CAP1: begin
          prot_word_r <= mem_rdata;
          code_bits_r <= ~mem_rdata[`FETAR_BOOT_MSB:`FETAR_BOOT_LSB];
          init_r      <= IN_DONE;
        end
        default: begin
          init_r <= IN_DONE;
        end
      endcase
    end
  end

  // ==========================================================
  // program/erase sequencer
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (op_start_in && init_done) begin
          state_nxt = ST_PULSE;
          cnt_nxt   = phase_len(ST_PULSE, op_kind_in, page_erase_r, mod_erase_r,
                                end_r, mod_end_r, recovery_r);
        end
      end
      default: begin
        if (tick_r) begin
          if (cnt_r > 21'h00_0001) begin
            cnt_nxt = cnt_r - 21'h00_0001;
          end else begin
            case (state_r)
              ST_PULSE: begin
                state_nxt = ST_END;
              end
              ST_END: begin
                // extra end delay for module erase
                state_nxt = (op_r == `FETAR_OP_MOD_ERASE) ? ST_MEND : ST_RCV;
              end
              ST_MEND: begin
                state_nxt = ST_RCV;
              end
              default: begin
                state_nxt = ST_IDLE;
              end
            endcase
            cnt_nxt = phase_len(state_nxt, op_r, page_erase_r, mod_erase_r,
                                end_r, mod_end_r, recovery_r);
          end
        end
      end
    endcase
  end

  always @* begin
    // busy during init and every active phase
    busy_nxt = (state_nxt != ST_IDLE) | ~init_done;
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r         <= ST_IDLE;
      op_r            <= `FETAR_OP_PROGRAM;
      cnt_r           <= 21'h00_0000;
      busy_out        <= 1'b1;
      cpu_stall_out   <= 1'b0;
      prog_pulse_out  <= 1'b0;
      erase_pulse_out <= 1'b0;
      presc_tick_out  <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == ST_IDLE && op_start_in && init_done) begin
        op_r <= op_kind_in;
      end
      busy_out       <= busy_nxt;
      cpu_stall_out  <= busy_nxt & flash_req_in;
      presc_tick_out <= tick_r;
      // erase pulse held through pulse phase
      erase_pulse_out <= (state_nxt == ST_PULSE) &
                         ((state_r == ST_IDLE) ? (op_kind_in != `FETAR_OP_PROGRAM)
                                               : (op_r != `FETAR_OP_PROGRAM));
      prog_pulse_out  <= (state_nxt == ST_PULSE) &
                         ((state_r == ST_IDLE) ? (op_kind_in == `FETAR_OP_PROGRAM)
                                               : (op_r == `FETAR_OP_PROGRAM));
    end
  end

  // ==========================================================
  // usb power and boot branch
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      usb_lowpower_out <= 1'b1;
      boot_branch_out  <= 1'b0;
      boot_disp_out    <= 16'h0000;
    end else if (ce_in) begin
      usb_lowpower_out <= ~func_word_r[`FETAR_FUNC_USB_BIT] | usb_suspend_in;
      // branch once the copy is loaded
      boot_branch_out  <= (init_r == IN_CAP1);
      boot_disp_out    <= {3'h0, ~mem_rdata[`FETAR_BOOT_MSB:`FETAR_BOOT_LSB], 9'h000};
      if (init_done) begin
        boot_disp_out <= code_start;
      end
    end
  end

  // ==========================================================
  // register read path
  always @* begin
    rdata_nxt = 16'h0000;
    if (cpu_addr_in == `FETAR_IDX_PRESCALE) begin
      rdata_nxt = {11'h000, presc_div_r};
    end else if (cpu_addr_in == `FETAR_IDX_PAGE_ERASE) begin
      rdata_nxt = {8'h00, page_erase_r};
    end else if (cpu_addr_in == `FETAR_IDX_MOD_ERASE) begin
      rdata_nxt = {8'h00, mod_erase_r};
    end else if (cpu_addr_in == `FETAR_IDX_END) begin
      rdata_nxt = {8'h00, end_r};
    end else if (cpu_addr_in == `FETAR_IDX_MOD_END) begin
      rdata_nxt = {8'h00, mod_end_r};
    end else if (cpu_addr_in == `FETAR_IDX_RECOVERY) begin
      rdata_nxt = {8'h00, recovery_r};
    end else if (cpu_addr_in == `FETAR_IDX_FUNC_WORD || cpu_addr_in == `FETAR_IDX_FUNC_ALIAS) begin
      rdata_nxt = func_word_r;
    end else if (cpu_addr_in == `FETAR_IDX_PROT_WORD || cpu_addr_in == `FETAR_IDX_PROT_ALIAS) begin
      rdata_nxt = prot_word_r;
    end else if (cpu_addr_in == `FETAR_IDX_CODE_START || cpu_addr_in == `FETAR_IDX_CODE_ALIAS) begin
      rdata_nxt = code_start;
    end else if (cpu_addr_in == `FETAR_IDX_STATUS) begin
      rdata_nxt = {13'h0000, state_r != ST_IDLE, ~init_done, busy_out};
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      if (cpu_sel_in && !cpu_wr_in) begin
        cpu_rdata_out <= rdata_nxt;
      end
    end
  end

endmodule // fetar_top

/* File: verif/fetar_checker.sv */
// checker: timing and read-port relations seen at the fetar_top ports
// assumes bind onto fetar_top, one clock domain, reset active high
`timescale 1ns/1ps
module fetar_checker #(
  parameter [20:0] PROG_TICKS = 21'h00_0008
) (
  input wire        clock_in,
  input wire        rst_in,
  input wire        cpu_sel_in,
  input wire        cpu_wr_in,
  input wire [15:0] cpu_rdata_out,
  input wire        flash_req_in,
  input wire        cpu_stall_out,
  input wire        op_start_in,
  input wire [1:0]  op_kind_in,
  input wire        busy_out,
  input wire        prog_pulse_out,
  input wire        erase_pulse_out,
  input wire        usb_suspend_in,
  input wire        usb_lowpower_out,
  input wire        boot_branch_out,
  input wire [15:0] boot_disp_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ======================================================
  // assertions
  pulse_busy_a: assert property ((prog_pulse_out || erase_pulse_out) |-> busy_out)
    else $error("pulse without busy");
  pulse_excl_a: assert property (!(prog_pulse_out && erase_pulse_out))
    else $error("both pulses high");
  stall_req_a: assert property (cpu_stall_out == ($past(flash_req_in) && busy_out))
    else $error("stall not tied to busy and request");
  prog_start_a: assert property (op_start_in && !busy_out && op_kind_in == 2'h0 |=> prog_pulse_out)
    else $error("program start missed");
  erase_start_a: assert property (op_start_in && !busy_out && op_kind_in != 2'h0 |=> erase_pulse_out)
    else $error("erase start missed");
  erase_min_a: assert property ($rose(erase_pulse_out) |-> erase_pulse_out [*8])
    else $error("erase pulse too short");
  prog_min_a: assert property ($rose(prog_pulse_out) |-> prog_pulse_out [*8])
    else $error("program pulse too short");
  usb_force_a: assert property (usb_suspend_in |=> usb_lowpower_out)
    else $error("suspend not low power");
  rdata_hold_a: assert property (!(cpu_sel_in && !cpu_wr_in) |=> $stable(cpu_rdata_out))
    else $error("read data moved without read");
  disp_zero_a: assert property (boot_disp_out[8:0] == 9'h000 && boot_disp_out[15:13] == 3'h0)
    else $error("fixed displacement bits nonzero");
  branch_pulse_a: assert property (boot_branch_out |=> !boot_branch_out)
    else $error("branch pulse longer than one cycle");
  cover property ($rose(erase_pulse_out));
  cover property ($rose(prog_pulse_out));
  cover property (cpu_stall_out);
endmodule // fetar_checker

bind fetar_top fetar_checker #(.PROG_TICKS(PROG_TICKS)) fetar_checker_i (
  .clock_in, .rst_in, .cpu_sel_in, .cpu_wr_in, .cpu_rdata_out, .flash_req_in,
  .cpu_stall_out, .op_start_in, .op_kind_in, .busy_out, .prog_pulse_out,
  .erase_pulse_out, .usb_suspend_in, .usb_lowpower_out, .boot_branch_out, .boot_disp_out
);

/* File: verif/fetar_flash_model.sv */
// flash information block side: writes the two info words while reset holds
// assumes reset lasts at least three clocks
`timescale 1ns/1ps
module fetar_flash_model (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire [15:0] func_in,
  input  wire [15:0] prot_in,
  output reg         info_wr_out,
  output reg  [1:0]  info_waddr_out,
  output reg  [15:0] info_wdata_out
);
  reg [1:0] step_r;
  initial begin
    step_r = 2'h0;
    info_wr_out = 1'b0;
    info_waddr_out = 2'h0;
    info_wdata_out = 16'h0000;
  end
  always @(posedge clock_in) begin
    if (rst_in && step_r != 2'h2) begin
      info_wr_out <= 1'b1;
      info_waddr_out <= step_r;
      info_wdata_out <= step_r[0] ? prot_in : func_in;
      step_r <= step_r + 2'h1;
    end else begin
      // released bus toggles so a stale word is never mistaken for a live one
      info_wr_out <= 1'b0;
      info_wdata_out <= ~info_wdata_out;
      if (!rst_in) begin
        step_r <= 2'h0;
      end
    end
  end
endmodule // fetar_flash_model

/* File: verif/testbench.sv */
// self-checking bench for fetar_top with the info block model
// assumes 200 MHz clock, inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
  reg         clock_in, rst_in, cpu_sel_in, cpu_wr_in, flash_req_in, op_start_in, usb_suspend_in;
  reg         ce_in;
  reg  [3:0]  cpu_addr_in;
  reg  [7:0]  cpu_wdata_in;
  reg  [1:0]  op_kind_in;
  reg  [15:0] func_word, prot_word;
  wire [15:0] cpu_rdata_out, boot_disp_out, info_wdata;
  wire        cpu_stall_out, busy_out, prog_pulse_out, erase_pulse_out, presc_tick_out;
  wire        usb_lowpower_out, boot_branch_out, info_wr;
  wire [1:0]  info_waddr;
  integer     error_cnt, n_compared, i;
  fetar_top fetar_top_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .cpu_sel_in(cpu_sel_in),
    .cpu_wr_in(cpu_wr_in), .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in),
    .cpu_rdata_out(cpu_rdata_out), .flash_req_in(flash_req_in), .cpu_stall_out(cpu_stall_out),
    .op_start_in(op_start_in), .op_kind_in(op_kind_in), .busy_out(busy_out),
    .prog_pulse_out(prog_pulse_out), .erase_pulse_out(erase_pulse_out), .presc_tick_out(presc_tick_out),
    .info_wr_in(info_wr), .info_waddr_in(info_waddr), .info_wdata_in(info_wdata),
    .usb_suspend_in(usb_suspend_in), .usb_lowpower_out(usb_lowpower_out),
    .boot_branch_out(boot_branch_out), .boot_disp_out(boot_disp_out));
  fetar_flash_model fetar_flash_model_i (.clock_in(clock_in), .rst_in(rst_in), .func_in(func_word),
    .prot_in(prot_word), .info_wr_out(info_wr), .info_waddr_out(info_waddr), .info_wdata_out(info_wdata));
  // ======================================================
  // shared tasks
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task cyc(input [3:0] a, input wr, input [7:0] d);
    begin
      @(posedge clock_in);
      #1;
      cpu_sel_in = 1'b1;
      cpu_wr_in = wr;
      cpu_addr_in = a;
      cpu_wdata_in = d;
      @(posedge clock_in);
      #1;
      cpu_sel_in = 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [15:0] exp);
    begin
      cyc(a, 1'b0, 8'h00);
      check(cpu_rdata_out, exp);
    end
  endtask
  task do_reset;
    integer br;
    begin
      br = 0;
      rst_in = 1'b1;
      repeat (16) @(posedge clock_in);
      #1;
      rst_in = 1'b0;
      // look a step after each edge, never in the edge's own time step
      for (i = 0; i < 40 && busy_out !== 1'b0; i = i + 1) begin
        @(posedge clock_in);
        #1;
        br = br + boot_branch_out;
      end
      check({15'h0000, busy_out}, 16'h0000);
      check(br[15:0], 16'h0001);
    end
  endtask
  // slack covers the tick alignment at each phase boundary
  task run_op(input [1:0] k, input integer e_pw, input integer e_tail, input integer slack);
    integer pw, tl;
    begin
      @(posedge clock_in);
      #1;
      op_start_in = 1'b1;
      op_kind_in = k;
      flash_req_in = 1'b1;
      @(posedge clock_in);
      #1;
      op_start_in = 1'b0;
      check({15'h0000, cpu_stall_out}, 16'h0001);
      pw = 0;
      tl = 0;
      while ((prog_pulse_out | erase_pulse_out) === 1'b1 && pw < 40000) begin
        @(posedge clock_in);
        #1;
        pw = pw + 1;
      end
      while (busy_out === 1'b1 && tl < 4000) begin
        @(posedge clock_in);
        #1;
        tl = tl + 1;
      end
      flash_req_in = 1'b0;
      check({15'h0000, pw > e_pw - slack && pw <= e_pw}, 16'h0001);
      check({15'h0000, tl >= e_tail && tl <= e_tail + 3 * slack}, 16'h0001);
    end
  endtask
  // ======================================================
  // scenarios
  task reset_values;
    integer n;
    begin
      // clock enable low: this write must not land
      ce_in = 1'b0;
      cyc(4'h1, 1'b1, 8'h77);
      ce_in = 1'b1;
      rd_chk(4'h0, 16'h0004);
      rd_chk(4'h1, 16'h0004);
      rd_chk(4'h2, 16'h00EA);
      rd_chk(4'h3, 16'h0018);
      rd_chk(4'h4, 16'h003C);
      rd_chk(4'h5, 16'h0004);
      n = 0;
      repeat (20) begin
        @(posedge clock_in);
        #1;
        n = n + presc_tick_out;
      end
      check(n[15:0], 16'h0004);
    end
  endtask
  task auto_read;
    begin
      for (i = 6; i < 9; i = i + 1) cyc(i[3:0], 1'b1, 8'h00);
      for (i = 6; i < 12; i = i + 3) begin
        rd_chk(i[3:0], 16'h1234);
        rd_chk(i[3:0] + 4'h1, 16'hA5A5);
        rd_chk(i[3:0] + 4'h2, 16'h1400);
      end
      check(boot_disp_out, 16'h1400);
      check({15'h0000, usb_lowpower_out}, 16'h0001);
    end
  endtask
  task timing_ops;
    begin
      cyc(4'h0, 1'b1, 8'h01);
      cyc(4'h3, 1'b1, 8'h00);
      cyc(4'h5, 1'b1, 8'h00);
      run_op(2'h0, 16, 4, 2);
      cyc(4'h0, 1'b1, 8'h00);
      cyc(4'h1, 1'b1, 8'h00);
      cyc(4'h2, 1'b1, 8'h00);
      cyc(4'h3, 1'b1, 8'h02);
      cyc(4'h4, 1'b1, 8'h00);
      cyc(4'h5, 1'b1, 8'h01);
      run_op(2'h1, 4096, 5, 1);
      run_op(2'h2, 4096, 13, 1);
      rd_chk(4'h3, 16'h0002);
      rd_chk(4'h1, 16'h0000);
    end
  endtask
  task usb_follow;
    begin
      func_word = 16'h0001;
      @(posedge clock_in);
      #1;
      op_start_in = 1'b1;
      @(posedge clock_in);
      #1;
      op_start_in = 1'b0;
      do_reset;
      rd_chk(4'h1, 16'h0004);
      check({15'h0000, usb_lowpower_out}, 16'h0000);
      usb_suspend_in = 1'b1;
      @(posedge clock_in);
      #1;
      check({15'h0000, usb_lowpower_out}, 16'h0001);
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    #250000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial begin
    {rst_in, cpu_sel_in, cpu_wr_in, flash_req_in, op_start_in, usb_suspend_in} = 6'b10_0000;
    ce_in = 1'b1;
    cpu_addr_in = 4'h0;
    cpu_wdata_in = 8'h00;
    op_kind_in = 2'h1;
    func_word = 16'h1234;
    prot_word = 16'hA5A5;
    error_cnt = 0;
    n_compared = 0;
    do_reset;
    reset_values;
    auto_read;
    timing_ops;
    usb_follow;
    end_of_test;
  end
endmodule // testbench
